// ---- logic/compact_timer.sv ----
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - ten-bit counter advances on selected clock ticks
// - clock select picks system, divided, sub or pin
// - comparator A matches all ten bits
// - comparator P matches top three bits, low seven bits zero
// - software only clears counter via on rising
// - overflow or selected match clears; only A and P matches raise events, overflow none
// - separate event outputs for A and P
// - pause holds count, resume from held value
// - off holds count; turning on clears it
// - turning on restores initial output level in compare mode
// - match A drives pin low, high or toggle in compare mode
// - complementary pin is always the inverse
// - low write buffered, high write commits both
// - high read latches low byte into buffer
// - counter read-only, compare A read-write
// - control A layout pause,clock,on,period; zero reset
// - period n gives n*128 ticks, zero 1024
// - clear source selects A or P/overflow outside PWM mode
// - mode: compare, PWM, timer; 01 undefined
// - initial level or PWM active polarity
module compact_timer
  import timer_pkg::*;
(
  // clock and reset
  input  wire logic              REF_CLK_I,
  input  wire logic              RST_N_I,
  // apb slave
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  input  wire logic [3:0]        PSTRB_I,
  output logic [31:0]            PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  // clock sources
  input  wire logic              TIMER_EXT_CLOCK_PIN_I,
  input  wire logic              SUB_CLOCK_I,
  // pins
  output logic                   TIMER_OUT_PIN_O,
  output logic                   TIMER_OUT_PIN_INV_O,
  // events
  output logic                   MATCH_A_EVENT_O,
  output logic                   MATCH_P_EVENT_O
);

  // register state
  logic [7:0]       timer_control_a;
  logic [7:0]       timer_control_b;
  logic [CNT_W-1:0] compare_a_value;
  logic [7:0]       byte_buf;
  logic [7:0]       rd_data;
  logic [7:0]       snap_low;
  logic [7:0]       next_timer_control_a;
  logic [7:0]       next_timer_control_b;
  logic [CNT_W-1:0] next_compare_a_value;
  logic [7:0]       next_byte_buf;
  logic [7:0]       next_rd_data;
  logic [7:0]       next_snap_low;

  // counter state
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             on_prev;
  logic             next_on_prev;
  logic             match_a_q;
  logic             match_p_q;
  logic             next_match_a_q;
  logic             next_match_p_q;

  // decoded fields
  logic             count_pause;
  logic [2:0]       clock_select;
  logic             timer_on;
  logic [2:0]       period_compare_field;
  logic [1:0]       mode_select;
  logic [1:0]       out_action;
  logic             output_initial_level;
  logic             out_invert;
  logic             duty_swap;
  logic             clear_source_select;

  // bus and counter helpers
  logic             setup;
  logic             access;
  logic             known;
  logic             wr_en;
  logic             rd_acc;
  logic             run;
  logic             tick;
  logic             on_rise;
  logic [CNT_W:0]   inc;
  logic             match_a;
  logic             match_p;
  logic             ovf;
  logic             clr;

  assign count_pause          = timer_control_a[CA_PAUSE_BIT];
  assign clock_select         = timer_control_a[CA_CKS_LSB +: 3];
  assign timer_on             = timer_control_a[CA_ON_BIT];
  assign period_compare_field = timer_control_a[CA_PER_LSB +: 3];
  assign mode_select          = timer_control_b[CB_MODE_LSB +: 2];
  assign out_action           = timer_control_b[CB_IO_LSB +: 2];
  assign output_initial_level = timer_control_b[CB_OC_BIT];
  assign out_invert           = timer_control_b[CB_POL_BIT];
  assign duty_swap            = timer_control_b[CB_DPX_BIT];
  assign clear_source_select  = timer_control_b[CB_CCLR_BIT];

  // zero-wait slave: read data is captured during setup
  assign setup     = PSEL_I & ~PENABLE_I;
  assign access    = PSEL_I & PENABLE_I;
  assign known     = addr_known(PADDR_I);
  assign wr_en     = access & PWRITE_I & PSTRB_I[0] & known;
  assign rd_acc    = access & ~PWRITE_I;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = access & ~known;
  assign PRDATA_O  = {24'h000000, rd_data};

  always_comb begin
    next_timer_control_a = timer_control_a;
    next_timer_control_b = timer_control_b;
    next_compare_a_value = compare_a_value;
    next_byte_buf        = byte_buf;
    next_rd_data         = rd_data;
    next_snap_low        = snap_low;
    if (setup && !PWRITE_I) begin
      unique case (PADDR_I)
        OFF_CTRL_A: next_rd_data = timer_control_a;
        OFF_CTRL_B: next_rd_data = timer_control_b;
        OFF_CNT_LO: next_rd_data = byte_buf;
        OFF_CNT_HI: begin
          next_rd_data  = {6'h00, count[9:8]};
          next_snap_low = count[7:0];
        end
        OFF_CMP_LO: next_rd_data = byte_buf;
        OFF_CMP_HI: begin
          next_rd_data  = {6'h00, compare_a_value[9:8]};
          next_snap_low = compare_a_value[7:0];
        end
        default:    next_rd_data = 8'h00;
      endcase
    end
    // the low byte is taken at setup with the high byte, buffered at the access edge
    if (rd_acc && (PADDR_I == OFF_CNT_HI || PADDR_I == OFF_CMP_HI)) begin
      next_byte_buf = snap_low;
    end
    if (wr_en) begin
      unique case (PADDR_I)
        OFF_CTRL_A: next_timer_control_a = PWDATA_I[7:0];
        OFF_CTRL_B: next_timer_control_b = PWDATA_I[7:0];
        OFF_CMP_LO: next_byte_buf = PWDATA_I[7:0];
        OFF_CMP_HI: next_compare_a_value = {PWDATA_I[1:0], byte_buf};
        // counter bytes take no writes at all
        default:    next_byte_buf = byte_buf;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      timer_control_a <= CTRL_A_RST;
      timer_control_b <= CTRL_B_RST;
      compare_a_value <= CMPA_RST;
      byte_buf        <= 8'h00;
      rd_data         <= 8'h00;
      snap_low        <= 8'h00;
    end else begin
      timer_control_a <= next_timer_control_a;
      timer_control_b <= next_timer_control_b;
      compare_a_value <= next_compare_a_value;
      byte_buf        <= next_byte_buf;
      rd_data         <= next_rd_data;
      snap_low        <= next_snap_low;
    end
  end

  // counting stops while off or paused; the prescaler sleeps too
  assign run     = timer_on & ~count_pause;
  assign on_rise = timer_on & ~on_prev;

  timer_clock_source u_clock_source (
    .clk_i     (REF_CLK_I),
    .rst_n_i   (RST_N_I),
    .en_i      (run),
    .sel_i     (clock_select),
    .ext_pin_i (TIMER_EXT_CLOCK_PIN_I),
    .sub_pin_i (SUB_CLOCK_I),
    .tick_o    (tick)
  );

  // matching on the next value makes the period exactly n*128 ticks
  assign inc     = {1'b0, count} + 11'h001;
  assign match_a = tick & (inc[CNT_W-1:0] == compare_a_value);
  assign match_p = tick & (inc[9:7] == period_compare_field) &
                   (inc[6:0] == 7'h00);
  assign ovf     = tick & (count == CNT_MAX);

  always_comb begin
    if (mode_select == MODE_PWM) begin
      clr = duty_swap ? match_a : match_p;
    end else if (clear_source_select) begin
      clr = match_a;
    end else begin
      clr = match_p | ovf;
    end
  end

  always_comb begin
    next_on_prev   = timer_on;
    next_match_a_q = match_a;
    next_match_p_q = match_p;
    next_count     = count;
    if (on_rise) begin
      next_count = '0;
    end else if (tick) begin
      next_count = clr ? '0 : inc[CNT_W-1:0];
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      count     <= '0;
      on_prev   <= 1'b0;
      match_a_q <= 1'b0;
      match_p_q <= 1'b0;
    end else begin
      count     <= next_count;
      on_prev   <= next_on_prev;
      match_a_q <= next_match_a_q;
      match_p_q <= next_match_p_q;
    end
  end

  assign MATCH_A_EVENT_O = match_a_q;
  assign MATCH_P_EVENT_O = match_p_q;

  timer_output_stage u_output_stage (
    .clk_i        (REF_CLK_I),
    .rst_n_i      (RST_N_I),
    .mode_i       (mode_select),
    .action_i     (out_action),
    .init_level_i (output_initial_level),
    .invert_i     (out_invert),
    .dpx_i        (duty_swap),
    .on_rise_i    (on_rise),
    .match_a_i    (match_a),
    .count_i      (count),
    .cmp_a_i      (compare_a_value),
    .cmp_p_i      (period_compare_field),
    .pin_o        (TIMER_OUT_PIN_O),
    .pin_inv_o    (TIMER_OUT_PIN_INV_O)
  );

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  start_clear_a: assert property (on_rise |=> count == '0)
    else $error("counter not zero after turning on");

  off_hold_a: assert property (!timer_on ##1 !timer_on
    |-> $stable(count))
    else $error("counter moved while off");

  pause_hold_a: assert property ((count_pause && !on_rise) [*2]
    |-> $stable(count))
    else $error("counter moved while paused");

  count_step_a: assert property ((tick && !clr && !on_rise)
    |=> count == $past(inc[CNT_W-1:0]))
    else $error("counter did not advance by one");

  match_a_evt_a: assert property ((match_a && !on_rise)
    |=> MATCH_A_EVENT_O && (count == '0 || count == $past(compare_a_value)))
    else $error("comparator A event wrong");

  period_clear_a: assert property ((match_p && !on_rise &&
    mode_select != MODE_PWM && !clear_source_select)
    |=> MATCH_P_EVENT_O && count == '0)
    else $error("comparator P did not clear counter");

  pair_write_a: assert property ((wr_en && PADDR_I == OFF_CMP_HI)
    |=> compare_a_value == {$past(PWDATA_I[1:0]), $past(byte_buf)})
    else $error("compare A pair not committed together");

  pair_read_a: assert property ((setup && !PWRITE_I &&
    PADDR_I == OFF_CNT_HI) ##1 (access && !PWRITE_I && PADDR_I == OFF_CNT_HI)
    |=> byte_buf == $past(count[7:0], 2))
    else $error("counter low byte not latched on high read");

  ro_count_a: assert property ((wr_en && (PADDR_I == OFF_CNT_LO ||
    PADDR_I == OFF_CNT_HI)) |=> $stable(compare_a_value) &&
    $stable(timer_control_a))
    else $error("write to counter bytes had an effect");

endmodule

// ---- logic/timer_clock_source.sv ----
`timescale 1ns/1ps
module timer_clock_source
  import timer_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // control
  input  wire logic       en_i,
  input  wire logic [2:0] sel_i,
  // sources
  input  wire logic       ext_pin_i,
  input  wire logic       sub_pin_i,
  // counter advance enable
  output logic            tick_o
);

  logic [5:0] div_cnt;
  logic [5:0] next_div_cnt;
  logic       ext_s1;
  logic       ext_s2;
  logic       ext_s3;
  logic       sub_d;
  logic       ext_rise;
  logic       ext_fall;

  // the pin passes two flops before any edge logic sees it
  assign ext_rise = ext_s2 & ~ext_s3;
  assign ext_fall = ~ext_s2 & ext_s3;

  always_comb begin
    // prescaler sleeps while the timer is stopped to save power
    next_div_cnt = en_i ? div_cnt + 6'h01 : 6'h00;
  end

  always_comb begin
    tick_o = 1'b0;
    if (en_i) begin
      unique case (sel_i)
        CKS_SYS4:     tick_o = (div_cnt[1:0] == DIV4_LAST[1:0]);
        CKS_SYS:      tick_o = 1'b1;
        CKS_HI16:     tick_o = (div_cnt[3:0] == DIV16_LAST[3:0]);
        CKS_HI64:     tick_o = (div_cnt == DIV64_LAST);
        CKS_SUB_A,
        CKS_SUB_B:    tick_o = sub_pin_i & ~sub_d;
        CKS_EXT_RISE: tick_o = ext_rise;
        CKS_EXT_FALL: tick_o = ext_fall;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt <= 6'h00;
      ext_s1  <= 1'b0;
      ext_s2  <= 1'b0;
      ext_s3  <= 1'b0;
      sub_d   <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      ext_s1  <= ext_pin_i;
      ext_s2  <= ext_s1;
      ext_s3  <= ext_s2;
      sub_d   <= sub_pin_i;
    end
  end

  sys4_rate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (en_i && sel_i == CKS_SYS4 && tick_o) ##1 (en_i && sel_i == CKS_SYS4)
    [*3] |-> !tick_o)
    else $error("divide-by-4 tick came early");

endmodule

// ---- logic/timer_output_stage.sv ----
`timescale 1ns/1ps
module timer_output_stage
  import timer_pkg::*;
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // configuration
  input  wire logic [1:0]       mode_i,
  input  wire logic [1:0]       action_i,
  input  wire logic             init_level_i,
  input  wire logic             invert_i,
  input  wire logic             dpx_i,
  // timer state
  input  wire logic             on_rise_i,
  input  wire logic             match_a_i,
  input  wire logic [CNT_W-1:0] count_i,
  input  wire logic [CNT_W-1:0] cmp_a_i,
  input  wire logic [2:0]       cmp_p_i,
  // pins
  output logic                  pin_o,
  output logic                  pin_inv_o
);

  logic cm_level;
  logic next_cm_level;
  logic pin;
  logic next_pin;
  logic duty_on;
  logic pwm_level;

  always_comb begin
    next_cm_level = cm_level;
    if (on_rise_i) begin
      next_cm_level = init_level_i;
    end else if (match_a_i && mode_i == MODE_CMP) begin
      unique case (action_i)
        IO_NONE: next_cm_level = cm_level;
        IO_LOW:  next_cm_level = 1'b0;
        IO_HIGH: next_cm_level = 1'b1;
        IO_TOG:  next_cm_level = ~cm_level;
      endcase
    end
  end

  always_comb begin
    // edge aligned: active from counter clear until the duty value
    duty_on = dpx_i ? (count_i[CNT_W-1:CNT_W-3] < cmp_p_i)
                    : (count_i < cmp_a_i);
    unique case (action_i)
      2'h0:    pwm_level = ~init_level_i;
      2'h1:    pwm_level = init_level_i;
      2'h2:    pwm_level = duty_on ? init_level_i : ~init_level_i;
      default: pwm_level = ~init_level_i;
    endcase
    unique case (mode_i)
      MODE_CMP: next_pin = cm_level ^ invert_i;
      MODE_PWM: next_pin = (on_rise_i ? ~init_level_i : pwm_level) ^ invert_i;
      // timer mode and the undefined code leave the pin parked low
      default:  next_pin = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cm_level <= 1'b0;
      pin      <= 1'b0;
    end else begin
      cm_level <= next_cm_level;
      pin      <= next_pin;
    end
  end

  assign pin_o     = pin;
  assign pin_inv_o = ~pin;

  restart_level_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (on_rise_i && mode_i == MODE_CMP) ##1 (mode_i == MODE_CMP)
    |=> pin_o == ($past(init_level_i, 2) ^ $past(invert_i)))
    else $error("pin not back at initial level after restart");

endmodule

// ---- logic/timer_pkg.sv ----
package timer_pkg;

  // widths
  localparam int unsigned CNT_W  = 10;
  localparam int unsigned ADDR_W = 8;

  // register byte addresses on the bus
  localparam logic [ADDR_W-1:0] OFF_CTRL_A = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL_B = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CNT_LO = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CNT_HI = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CMP_LO = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CMP_HI = 8'h14;

  // timer_control_a fields
  localparam int unsigned CA_PAUSE_BIT = 7;
  localparam int unsigned CA_CKS_LSB   = 4;
  localparam int unsigned CA_ON_BIT    = 3;
  localparam int unsigned CA_PER_LSB   = 0;

  // timer_control_b fields
  localparam int unsigned CB_MODE_LSB  = 6;
  localparam int unsigned CB_IO_LSB    = 4;
  localparam int unsigned CB_OC_BIT    = 3;
  localparam int unsigned CB_POL_BIT   = 2;
  localparam int unsigned CB_DPX_BIT   = 1;
  localparam int unsigned CB_CCLR_BIT  = 0;

  // reset values and counter maximum
  localparam logic [7:0]       CTRL_A_RST = 8'h00;
  localparam logic [7:0]       CTRL_B_RST = 8'h00;
  localparam logic [CNT_W-1:0] CMPA_RST   = 10'h000;
  localparam logic [CNT_W-1:0] CNT_MAX    = 10'h3FF;

  // mode_select codes
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;

  // output action codes
  localparam logic [1:0] IO_NONE = 2'h0;
  localparam logic [1:0] IO_LOW  = 2'h1;
  localparam logic [1:0] IO_HIGH = 2'h2;
  localparam logic [1:0] IO_TOG  = 2'h3;

  // clock_select codes
  localparam logic [2:0] CKS_SYS4     = 3'h0;
  localparam logic [2:0] CKS_SYS      = 3'h1;
  localparam logic [2:0] CKS_HI16     = 3'h2;
  localparam logic [2:0] CKS_HI64     = 3'h3;
  localparam logic [2:0] CKS_SUB_A    = 3'h4;
  localparam logic [2:0] CKS_SUB_B    = 3'h5;
  localparam logic [2:0] CKS_EXT_RISE = 3'h6;
  localparam logic [2:0] CKS_EXT_FALL = 3'h7;

  // prescaler terminal counts
  localparam logic [5:0] DIV4_LAST  = 6'h03;
  localparam logic [5:0] DIV16_LAST = 6'h0F;
  localparam logic [5:0] DIV64_LAST = 6'h3F;

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return (a == OFF_CTRL_A) || (a == OFF_CTRL_B) || (a == OFF_CNT_LO) ||
           (a == OFF_CNT_HI) || (a == OFF_CMP_LO) || (a == OFF_CMP_HI);
  endfunction

endpackage

// ---- verification/test_compact_timer.sv ----
`timescale 1ns/1ps
module test_compact_timer
  import timer_pkg::*;
;
  logic              ref_clk;
  logic              rst_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              ext_pin;
  logic              sub_clk;
  logic              pin;
  logic              pin_inv;
  logic              ev_a;
  logic              ev_p;
  logic [1:0]        div;
  logic [31:0]       rdv;
  logic              rerr;
  logic [9:0]        c0;
  logic [9:0]        c1;
  int                error_cnt;
  int                compares;
  int                n;
  int                ticks [8] = '{4, 1, 16, 64, 2, 2, 6, 6};
  int                pers  [3] = '{1, 7, 0};
  logic [7:0]        pcb   [4] = '{8'h19, 8'h39, 8'h21, 8'h1D};
  logic              pex   [4] = '{1'h0, 1'h0, 1'h1, 1'h0};

  compact_timer u_dut (
    .REF_CLK_I             (ref_clk),
    .RST_N_I               (rst_n),
    .PSEL_I                (psel),
    .PENABLE_I             (penable),
    .PWRITE_I              (pwrite),
    .PADDR_I               (paddr),
    .PWDATA_I              (pwdata),
    .PSTRB_I               (4'hF),
    .PRDATA_O              (prdata),
    .PREADY_O              (pready),
    .PSLVERR_O             (pslverr),
    .TIMER_EXT_CLOCK_PIN_I (ext_pin),
    .SUB_CLOCK_I           (sub_clk),
    .TIMER_OUT_PIN_O       (pin),
    .TIMER_OUT_PIN_INV_O   (pin_inv),
    .MATCH_A_EVENT_O       (ev_a),
    .MATCH_P_EVENT_O       (ev_p)
  );

  always #4 ref_clk = ~ref_clk;

  // sub clock rises every 2 cycles, external pin every 6
  // pins are taken as already routed to the timer
  always @(posedge ref_clk) begin
    sub_clk <= ~sub_clk;
    if (div == 2'h2) begin
      div     <= 2'h0;
      ext_pin <= ~ext_pin;
    end else begin
      div <= div + 2'h1;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge ref_clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    rdv = prdata;
    rerr = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  // high byte first so the low byte comes from the same snapshot
  task automatic rd_cnt(output logic [9:0] v);
    apb(1'h0, OFF_CNT_HI, 8'h00);
    v[9:8] = rdv[1:0];
    apb(1'h0, OFF_CNT_LO, 8'h00);
    v[7:0] = rdv[7:0];
  endtask

  task automatic set_cmp(input logic [9:0] v);
    apb(1'h1, OFF_CMP_LO, v[7:0]);
    apb(1'h1, OFF_CMP_HI, {6'h00, v[9:8]});
  endtask

  // off then on, so every start is a fresh on edge
  task automatic start(input logic [7:0] cb, input logic [7:0] ca);
    apb(1'h1, OFF_CTRL_B, cb);
    apb(1'h1, OFF_CTRL_A, ca & 8'hF7);
    apb(1'h1, OFF_CTRL_A, ca | 8'h08);
  endtask

  // skips the first pulse, which may belong to the previous setup
  task automatic gap(input logic p, output int k);
    k = 0;
    repeat (2) do @(posedge ref_clk); while ((p ? ev_p : ev_a) !== 1'h1);
    do begin
      @(posedge ref_clk);
      k++;
    end while ((p ? ev_p : ev_a) !== 1'h1);
  endtask

  always @(negedge ref_clk) begin
    if (rst_n === 1'h1) begin
      chk("pin_inv", {31'h0, ~pin}, {31'h0, pin_inv});
    end
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    error_cnt++;
    $display("ERROR watchdog expected finish seen timeout");
    stop_test();
  end

  initial begin
    ref_clk = 1'h0;
    rst_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_pin = 1'h0;
    sub_clk = 1'h0;
    div = 2'h0;
    error_cnt = 0;
    compares = 0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      apb(1'h0, 8'(i * 4), 8'h00);
      chk("reset value", 32'h0, rdv);
    end
    apb(1'h1, OFF_CTRL_A, 8'hF7);
    apb(1'h0, OFF_CTRL_A, 8'h00);
    chk("control_a", 32'hF7, rdv);
    apb(1'h1, OFF_CTRL_A, 8'h00);
    apb(1'h0, 8'h18, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    apb(1'h1, OFF_CMP_LO, 8'h55);
    apb(1'h0, OFF_CMP_HI, 8'h00);
    apb(1'h0, OFF_CMP_LO, 8'h00);
    chk("unlatched low", 32'h0, rdv);
    apb(1'h1, OFF_CMP_LO, 8'h55);
    apb(1'h1, OFF_CMP_HI, 8'h02);
    apb(1'h0, OFF_CMP_HI, 8'h00);
    chk("compare high", 32'h2, rdv);
    apb(1'h0, OFF_CMP_LO, 8'h00);
    chk("compare low", 32'h55, rdv);
    set_cmp(10'h104);
    start(8'hC1, 8'h18);
    gap(1'h0, n);
    chk("ten bit match gap", 32'd260, n);
    chk("timer mode pin", 32'h0, {31'h0, pin});
    set_cmp(10'h003);
    for (int k = 0; k < 8; k++) begin
      start(8'hC1, {1'h0, 3'(k), 4'h8});
      gap(1'h0, n);
      chk("clock select gap", ticks[k] * 3, n);
    end
    for (int k = 0; k < 3; k++) begin
      start(8'hC0, 8'h18 | 8'(pers[k]));
      gap(1'h1, n);
      chk("period gap", pers[k] == 0 ? 1024 : pers[k] * 128, n);
    end
    start(8'hC0, 8'h08);
    repeat (40) @(posedge ref_clk);
    apb(1'h1, OFF_CTRL_A, 8'h88);
    rd_cnt(c0);
    apb(1'h1, OFF_CNT_LO, 8'hFF);
    apb(1'h1, OFF_CNT_HI, 8'h03);
    repeat (20) @(posedge ref_clk);
    rd_cnt(c1);
    chk("paused count", 32'(c0), 32'(c1));
    apb(1'h1, OFF_CTRL_A, 8'h08);
    repeat (40) @(posedge ref_clk);
    rd_cnt(c1);
    chk("resumed count", 32'h1, {31'h0, c1 > c0});
    apb(1'h1, OFF_CTRL_A, 8'h00);
    rd_cnt(c0);
    repeat (20) @(posedge ref_clk);
    rd_cnt(c1);
    chk("off count", 32'(c0), 32'(c1));
    apb(1'h1, OFF_CTRL_A, 8'h08);
    rd_cnt(c1);
    chk("on clears count", 32'h1, {31'h0, c1 < 10'h004});
    set_cmp(10'h064);
    // the last setup also inverts the pin
    for (int k = 0; k < 4; k++) begin
      start(pcb[k], 8'h18);
      repeat (3) @(posedge ref_clk);
      chk("initial level", {31'h0, pcb[k][3] ^ pcb[k][2]}, {31'h0, pin});
      do @(posedge ref_clk); while (ev_a !== 1'h1);
      repeat (2) @(posedge ref_clk);
      chk("match level", {31'h0, pex[k] ^ pcb[k][2]}, {31'h0, pin});
    end
    set_cmp(10'h020);
    for (int k = 0; k < 2; k++) begin
      start(k ? 8'hA8 : 8'hA0, 8'h19);
      repeat (8) @(posedge ref_clk);
      n = 0;
      repeat (128) begin
        @(posedge ref_clk);
        n += (pin === 1'h1);
      end
      chk("pwm high cycles", k ? 32 : 96, n);
    end
    stop_test();
  end
endmodule
